// [src/isd_cmd_decoder.sv]
`timescale 1ns/10ps
// Operation
// - decode raw receive and raw send
// - decode addressed read and write
// - decode controller take, standby, pass
// - interface clear held 500 us
// - decode device clear, line state, local
// - decode trigger, remote enable, listener check
// - decode address, string end, end message
// - decode online, system control, time limits
// - decode serial poll, service request, parallel poll
// - decode status bit, poll configure, unconfigure
// - accept inquiry and sense opcodes
// - decode identify, configuration, status
// - decode event wait and command send
// - nonzero reserved field gives illegal request
// - command block is six bytes
// - selection with attention enters message out
// - status byte then one complete message
// - status reporting adds message in first
// - non-disconnecting commands stay connected
// - data in from bus, out to bus
module isd_cmd_decoder (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// selection from the scsi side (synchronous to sys_clk)
	input wire logic sel_req,
	input wire logic sel_atn,
	input wire logic cont_status_en,
	// initiator byte stream (message out, command, data out)
	input wire logic [7:0] ini_data,
	input wire logic ini_valid,
	output logic ini_ready_q,
	// target byte stream (data in, status, message in)
	output logic [7:0] tgt_data_q,
	output logic tgt_valid_q,
	input wire logic tgt_ready,
	// current phase
	output isd_pkg::isd_phase_t phase_q,
	output logic disc_allowed_q,
	// ieee 488 side data
	input wire logic [7:0] bus_rx_data,
	input wire logic bus_rx_valid,
	input wire logic bus_rx_end,
	output logic bus_rx_ready_q,
	output logic [7:0] bus_tx_data_q,
	output logic bus_tx_valid_q,
	input wire logic bus_tx_ready,
	// executor handoff
	output isd_pkg::isd_fn_t exec_fn_q,
	output logic [39:0] exec_args_q,
	output logic exec_start_q,
	input wire logic exec_done,
	input wire logic exec_error,
	// interface clear and sense
	output logic ifc_active_q,
	output logic [3:0] sense_key_q
);
	typedef enum {
		S_IDLE, S_MSG_OUT, S_CMD, S_LOOKUP, S_CHECK, S_EXEC, S_IFC, S_DATA_IN,
		S_DATA_OUT, S_REPORT, S_STATUS, S_MSG_IN
	} isd_state_t;

	isd_state_t state_q;
	logic [7:0] cdb_q [isd_pkg::CDB_LEN];
	logic [isd_pkg::CDB_IDX_W-1:0] idx_q;
	logic [31:0] count_q;
	logic [7:0] status_q;
	logic ident_disc_q;
	logic pending_q;
	logic ifc_start;
	logic ifc_line;
	logic ifc_done;
	isd_pkg::isd_fn_t fn_q;
	logic fn_in_q;
	logic fn_out_q;
	logic fn_disc_q;
	logic reserved_bad;
	logic tgt_take;
	logic ini_take;

	assign tgt_take = tgt_valid_q && tgt_ready;
	assign ini_take = ini_valid && ini_ready_q;

	isd_opcode_rom u_rom (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.opcode(cdb_q[0]),
		.fn_q(fn_q),
		.fn_data_in_q(fn_in_q),
		.fn_data_out_q(fn_out_q),
		.fn_disc_q(fn_disc_q)
	);

	isd_ifc_timer #(
		.CYCLES(isd_pkg::IFC_CYCLES)
	) u_ifc (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.start(ifc_start),
		.ifc_q(ifc_line),
		.done_q(ifc_done)
	);

	assign ifc_start = (state_q == S_CHECK) && !reserved_bad
		&& (fn_q == isd_pkg::FN_IFC_PULSE);

	// the last byte is reserved for every opcode here; unknown opcodes also refused
	assign reserved_bad = (cdb_q[isd_pkg::CDB_LAST] != 8'h00)
		|| (fn_q == isd_pkg::FN_NONE);

	// command block capture, six bytes in order
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < isd_pkg::CDB_LEN; i++) begin
				cdb_q[i] <= 8'h00;
			end
		end else if (state_q == S_CMD && ini_take) begin
			cdb_q[idx_q] <= ini_data;
		end
	end

	// main phase sequencer
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= S_IDLE;
			idx_q <= '0;
			count_q <= 32'h0000_0000;
			status_q <= isd_pkg::ST_GOOD;
			ident_disc_q <= 1'b0;
			pending_q <= 1'b0;
		end else begin
			case (state_q)
				S_IDLE: begin
					idx_q <= '0;
					if (sel_req) begin
						state_q <= sel_atn ? S_MSG_OUT : S_CMD;
						ident_disc_q <= 1'b0;
					end
				end
				S_MSG_OUT: begin
					if (ini_take) begin
						// identify bit 6 only records permission
						ident_disc_q <= ini_data[isd_pkg::IDENT_DISC_BIT];
						state_q <= S_CMD;
					end
				end
				S_CMD: begin
					if (ini_take) begin
						idx_q <= idx_q + 1'b1;
						if (idx_q == isd_pkg::CDB_IDX_W'(isd_pkg::CDB_LAST)) begin
							state_q <= S_LOOKUP;
						end
					end
				end
				S_LOOKUP: begin
					// one cycle for the registered opcode lookup
					state_q <= S_CHECK;
				end
				S_CHECK: begin
					count_q <= {cdb_q[1], cdb_q[2], cdb_q[3], cdb_q[4]};
					if (reserved_bad) begin
						status_q <= isd_pkg::ST_CHECK;
						state_q <= cont_status_en ? S_REPORT : S_STATUS;
					end else if (fn_q == isd_pkg::FN_IFC_PULSE) begin
						state_q <= S_IFC;
					end else if (fn_in_q) begin
						state_q <= S_DATA_IN;
					end else if (fn_out_q) begin
						state_q <= S_DATA_OUT;
					end else begin
						state_q <= S_EXEC;
						pending_q <= 1'b0;
					end
				end
				S_EXEC: begin
					pending_q <= 1'b1;
					if (pending_q && exec_done) begin
						status_q <= exec_error ? isd_pkg::ST_CHECK : isd_pkg::ST_GOOD;
						state_q <= cont_status_en ? S_REPORT : S_STATUS;
					end
				end
				S_IFC: begin
					if (ifc_done) begin
						status_q <= isd_pkg::ST_GOOD;
						state_q <= cont_status_en ? S_REPORT : S_STATUS;
					end
				end
				S_DATA_IN: begin
					if (count_q == 32'h0000_0000 || (bus_rx_end && bus_rx_ready_q)) begin
						status_q <= isd_pkg::ST_GOOD;
						state_q <= cont_status_en ? S_REPORT : S_STATUS;
					end else if (tgt_take) begin
						count_q <= count_q - 32'h0000_0001;
					end
				end
				S_DATA_OUT: begin
					if (count_q == 32'h0000_0000) begin
						status_q <= isd_pkg::ST_GOOD;
						state_q <= cont_status_en ? S_REPORT : S_STATUS;
					end else if (bus_tx_valid_q && bus_tx_ready) begin
						count_q <= count_q - 32'h0000_0001;
					end
				end
				S_REPORT: begin
					if (tgt_take) begin
						state_q <= S_STATUS;
					end
				end
				S_STATUS: begin
					if (tgt_take) begin
						state_q <= S_MSG_IN;
					end
				end
				S_MSG_IN: begin
					if (tgt_take) begin
						state_q <= S_IDLE;
					end
				end
				default: state_q <= S_IDLE;
			endcase
		end
	end

	// initiator-side acceptance: message out, command bytes, data out to bus
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ini_ready_q <= 1'b0;
			bus_tx_data_q <= 8'h00;
			bus_tx_valid_q <= 1'b0;
		end else begin
			ini_ready_q <= 1'b0;
			if (bus_tx_valid_q && bus_tx_ready) begin
				bus_tx_valid_q <= 1'b0;
			end
			case (state_q)
				S_MSG_OUT: ini_ready_q <= !ini_take;
				S_CMD: ini_ready_q <= !ini_take;
				S_DATA_OUT: begin
					// one byte in flight keeps the count exact
					ini_ready_q <= !bus_tx_valid_q && !ini_take && count_q != 32'h0000_0000;
					if (ini_take) begin
						bus_tx_data_q <= ini_data;
						bus_tx_valid_q <= 1'b1;
					end
				end
				default: ini_ready_q <= 1'b0;
			endcase
		end
	end

	// target-side bytes: bus data, optional report, status, complete message
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			tgt_data_q <= 8'h00;
			tgt_valid_q <= 1'b0;
			bus_rx_ready_q <= 1'b0;
		end else begin
			bus_rx_ready_q <= 1'b0;
			if (tgt_take) begin
				tgt_valid_q <= 1'b0;
			end
			case (state_q)
				S_DATA_IN: begin
					if (!tgt_valid_q && !bus_rx_ready_q && count_q != 32'h0000_0000) begin
						bus_rx_ready_q <= 1'b1;
					end
					if (bus_rx_ready_q && bus_rx_valid) begin
						tgt_data_q <= bus_rx_data;
						tgt_valid_q <= 1'b1;
					end
				end
				S_REPORT: if (!tgt_valid_q) begin
					tgt_data_q <= isd_pkg::MSG_STATUS_REPORT;
					tgt_valid_q <= 1'b1;
				end
				S_STATUS: if (!tgt_valid_q) begin
					tgt_data_q <= status_q;
					tgt_valid_q <= 1'b1;
				end
				S_MSG_IN: if (!tgt_valid_q) begin
					tgt_data_q <= isd_pkg::MSG_COMPLETE;
					tgt_valid_q <= 1'b1;
				end
				default: ;
			endcase
		end
	end

	// phase, executor handoff, sense key
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			phase_q <= isd_pkg::PH_FREE;
			disc_allowed_q <= 1'b0;
			exec_fn_q <= isd_pkg::FN_NONE;
			exec_args_q <= 40'h00_0000_0000;
			exec_start_q <= 1'b0;
			ifc_active_q <= 1'b0;
			sense_key_q <= isd_pkg::SENSE_NONE;
		end else begin
			ifc_active_q <= ifc_line;
			exec_start_q <= (state_q == S_CHECK) && !reserved_bad && !fn_in_q && !fn_out_q
				&& (fn_q != isd_pkg::FN_IFC_PULSE);
			if (state_q == S_CHECK) begin
				exec_fn_q <= fn_q;
				exec_args_q <= {cdb_q[1], cdb_q[2], cdb_q[3], cdb_q[4], cdb_q[5]};
				// a failed sense request keeps no stale key; sense itself reads it
				if (reserved_bad) begin
					sense_key_q <= isd_pkg::SENSE_ILLEGAL;
				end else if (fn_q != isd_pkg::FN_SENSE) begin
					sense_key_q <= isd_pkg::SENSE_NONE;
				end
			end
			disc_allowed_q <= ident_disc_q && fn_disc_q;
			case (state_q)
				S_IDLE: phase_q <= isd_pkg::PH_FREE;
				S_MSG_OUT: phase_q <= isd_pkg::PH_MSG_OUT;
				S_CMD, S_LOOKUP: phase_q <= isd_pkg::PH_COMMAND;
				S_DATA_IN: phase_q <= isd_pkg::PH_DATA_IN;
				S_DATA_OUT: phase_q <= isd_pkg::PH_DATA_OUT;
				S_REPORT, S_MSG_IN: phase_q <= isd_pkg::PH_MSG_IN;
				S_STATUS: phase_q <= isd_pkg::PH_STATUS;
				default: phase_q <= phase_q;
			endcase
		end
	end
endmodule : isd_cmd_decoder

// [src/isd_pkg.sv]
package isd_pkg;
	// opcodes
	localparam logic [7:0] OP_RAW_RECV = 8'hdd;
	localparam logic [7:0] OP_RAW_SEND = 8'hdc;
	localparam logic [7:0] OP_ADDR_READ = 8'hcf;
	localparam logic [7:0] OP_ADDR_WRITE = 8'hdb;
	localparam logic [7:0] OP_BECOME_CTRL = 8'hc0;
	localparam logic [7:0] OP_GO_STANDBY = 8'hc7;
	localparam logic [7:0] OP_PASS_CTRL = 8'hcc;
	localparam logic [7:0] OP_IFC_PULSE = 8'hd5;
	localparam logic [7:0] OP_DEV_CLEAR = 8'hc2;
	localparam logic [7:0] OP_LINE_STATE = 8'hc3;
	localparam logic [7:0] OP_GO_LOCAL = 8'hca;
	localparam logic [7:0] OP_TRIGGER = 8'hd9;
	localparam logic [7:0] OP_REMOTE_EN = 8'hd6;
	localparam logic [7:0] OP_LISTENER_CHECK = 8'hd2;
	localparam logic [7:0] OP_SET_ADDR = 8'hc1;
	localparam logic [7:0] OP_EOS_MODE = 8'hc5;
	localparam logic [7:0] OP_END_MODE = 8'hc6;
	localparam logic [7:0] OP_ONLINE = 8'hcb;
	localparam logic [7:0] OP_SYS_CTRL = 8'hd1;
	localparam logic [7:0] OP_TIME_LIMIT = 8'hd8;
	localparam logic [7:0] OP_SER_POLL = 8'hd3;
	localparam logic [7:0] OP_REQ_SERVICE = 8'hd4;
	localparam logic [7:0] OP_PAR_POLL = 8'hd0;
	localparam logic [7:0] OP_IST_BIT = 8'hc9;
	localparam logic [7:0] OP_PP_CONFIG = 8'hcd;
	localparam logic [7:0] OP_PP_UNCONFIG = 8'hce;
	localparam logic [7:0] OP_INQUIRY = 8'h12;
	localparam logic [7:0] OP_SENSE = 8'h03;
	localparam logic [7:0] OP_WHO_AM_I_QUERY = 8'hc8;
	localparam logic [7:0] OP_CONFIG = 8'hde;
	localparam logic [7:0] OP_STATUS = 8'hd7;
	localparam logic [7:0] OP_WAIT = 8'hda;
	localparam logic [7:0] OP_SEND_CMDS = 8'hc4;
	// command block layout
	localparam int CDB_LEN = 6;
	localparam int CDB_IDX_W = 3;
	localparam int CDB_LAST = 5;
	// status and messages
	localparam logic [7:0] ST_GOOD = 8'h00;
	localparam logic [7:0] ST_CHECK = 8'h02;
	localparam logic [7:0] MSG_COMPLETE = 8'h00;
	localparam logic [7:0] MSG_STATUS_REPORT = 8'h00;
	localparam logic [3:0] SENSE_NONE = 4'h0;
	localparam logic [3:0] SENSE_ILLEGAL = 4'h5;
	localparam int IDENT_DISC_BIT = 6;
	// timing
	localparam int CLK_HZ = 25000000;
	localparam int IFC_US = 500;
	localparam int IFC_CYCLES = (CLK_HZ / 1000000) * IFC_US;
	// function classes handed to the executor
	typedef enum logic [5:0] {
		FN_NONE, FN_RAW_RECV, FN_RAW_SEND, FN_ADDR_READ, FN_ADDR_WRITE,
		FN_BECOME_CTRL, FN_GO_STANDBY, FN_PASS_CTRL, FN_IFC_PULSE,
		FN_DEV_CLEAR, FN_LINE_STATE, FN_GO_LOCAL, FN_TRIGGER, FN_REMOTE_EN,
		FN_LISTENER_CHECK, FN_SET_ADDR, FN_EOS_MODE, FN_END_MODE, FN_ONLINE,
		FN_SYS_CTRL, FN_TIME_LIMIT, FN_SER_POLL, FN_REQ_SERVICE, FN_PAR_POLL,
		FN_IST_BIT, FN_PP_CONFIG, FN_PP_UNCONFIG, FN_INQUIRY, FN_SENSE,
		FN_WHO_AM_I_QUERY, FN_CONFIG, FN_STATUS, FN_WAIT, FN_SEND_CMDS
	} isd_fn_t;
	// scsi phases presented on the phase output
	typedef enum logic [2:0] {
		PH_FREE, PH_MSG_OUT, PH_COMMAND, PH_DATA_IN, PH_DATA_OUT,
		PH_STATUS, PH_MSG_IN
	} isd_phase_t;
endpackage : isd_pkg

// [src/isd_opcode_rom.sv]
`timescale 1ns/10ps
// registered opcode lookup: one cycle from opcode to class
module isd_opcode_rom (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// lookup
	input wire logic [7:0] opcode,
	output isd_pkg::isd_fn_t fn_q,
	output logic fn_data_in_q,
	output logic fn_data_out_q,
	output logic fn_disc_q
);
	function automatic isd_pkg::isd_fn_t isd_decode(input logic [7:0] op);
		case (op)
			isd_pkg::OP_RAW_RECV: isd_decode = isd_pkg::FN_RAW_RECV;
			isd_pkg::OP_RAW_SEND: isd_decode = isd_pkg::FN_RAW_SEND;
			isd_pkg::OP_ADDR_READ: isd_decode = isd_pkg::FN_ADDR_READ;
			isd_pkg::OP_ADDR_WRITE: isd_decode = isd_pkg::FN_ADDR_WRITE;
			isd_pkg::OP_BECOME_CTRL: isd_decode = isd_pkg::FN_BECOME_CTRL;
			isd_pkg::OP_GO_STANDBY: isd_decode = isd_pkg::FN_GO_STANDBY;
			isd_pkg::OP_PASS_CTRL: isd_decode = isd_pkg::FN_PASS_CTRL;
			isd_pkg::OP_IFC_PULSE: isd_decode = isd_pkg::FN_IFC_PULSE;
			isd_pkg::OP_DEV_CLEAR: isd_decode = isd_pkg::FN_DEV_CLEAR;
			isd_pkg::OP_LINE_STATE: isd_decode = isd_pkg::FN_LINE_STATE;
			isd_pkg::OP_GO_LOCAL: isd_decode = isd_pkg::FN_GO_LOCAL;
			isd_pkg::OP_TRIGGER: isd_decode = isd_pkg::FN_TRIGGER;
			isd_pkg::OP_REMOTE_EN: isd_decode = isd_pkg::FN_REMOTE_EN;
			isd_pkg::OP_LISTENER_CHECK: isd_decode = isd_pkg::FN_LISTENER_CHECK;
			isd_pkg::OP_SET_ADDR: isd_decode = isd_pkg::FN_SET_ADDR;
			isd_pkg::OP_EOS_MODE: isd_decode = isd_pkg::FN_EOS_MODE;
			isd_pkg::OP_END_MODE: isd_decode = isd_pkg::FN_END_MODE;
			isd_pkg::OP_ONLINE: isd_decode = isd_pkg::FN_ONLINE;
			isd_pkg::OP_SYS_CTRL: isd_decode = isd_pkg::FN_SYS_CTRL;
			isd_pkg::OP_TIME_LIMIT: isd_decode = isd_pkg::FN_TIME_LIMIT;
			isd_pkg::OP_SER_POLL: isd_decode = isd_pkg::FN_SER_POLL;
			isd_pkg::OP_REQ_SERVICE: isd_decode = isd_pkg::FN_REQ_SERVICE;
			isd_pkg::OP_PAR_POLL: isd_decode = isd_pkg::FN_PAR_POLL;
			isd_pkg::OP_IST_BIT: isd_decode = isd_pkg::FN_IST_BIT;
			isd_pkg::OP_PP_CONFIG: isd_decode = isd_pkg::FN_PP_CONFIG;
			isd_pkg::OP_PP_UNCONFIG: isd_decode = isd_pkg::FN_PP_UNCONFIG;
			isd_pkg::OP_INQUIRY: isd_decode = isd_pkg::FN_INQUIRY;
			isd_pkg::OP_SENSE: isd_decode = isd_pkg::FN_SENSE;
			isd_pkg::OP_WHO_AM_I_QUERY: isd_decode = isd_pkg::FN_WHO_AM_I_QUERY;
			isd_pkg::OP_CONFIG: isd_decode = isd_pkg::FN_CONFIG;
			isd_pkg::OP_STATUS: isd_decode = isd_pkg::FN_STATUS;
			isd_pkg::OP_WAIT: isd_decode = isd_pkg::FN_WAIT;
			isd_pkg::OP_SEND_CMDS: isd_decode = isd_pkg::FN_SEND_CMDS;
			default: isd_decode = isd_pkg::FN_NONE;
		endcase
	endfunction : isd_decode

	isd_pkg::isd_fn_t fn_d;
	assign fn_d = isd_decode(opcode);

	// data direction and disconnect capability per class
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			fn_q <= isd_pkg::FN_NONE;
			fn_data_in_q <= 1'b0;
			fn_data_out_q <= 1'b0;
			fn_disc_q <= 1'b0;
		end else begin
			fn_q <= fn_d;
			fn_data_in_q <= (fn_d == isd_pkg::FN_RAW_RECV) || (fn_d == isd_pkg::FN_ADDR_READ);
			fn_data_out_q <= (fn_d == isd_pkg::FN_RAW_SEND) || (fn_d == isd_pkg::FN_ADDR_WRITE)
				|| (fn_d == isd_pkg::FN_SEND_CMDS);
			// only the bulk transfers and wait may release the bus
			fn_disc_q <= (fn_d == isd_pkg::FN_RAW_RECV) || (fn_d == isd_pkg::FN_ADDR_READ)
				|| (fn_d == isd_pkg::FN_RAW_SEND) || (fn_d == isd_pkg::FN_ADDR_WRITE)
				|| (fn_d == isd_pkg::FN_WAIT);
		end
	end
endmodule : isd_opcode_rom

// [src/isd_ifc_timer.sv]
`timescale 1ns/10ps
// holds the interface clear line for a fixed number of cycles
module isd_ifc_timer #(
	parameter int CYCLES = isd_pkg::IFC_CYCLES
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// control
	input wire logic start,
	output logic ifc_q,
	output logic done_q
);
	localparam int CW = $clog2(CYCLES + 1);
	logic [CW-1:0] cnt_q;

	// a zero-length pulse would never raise done
	if (CYCLES < 1) begin : g_bad_cycles
		$error("ifc timer needs at least one cycle");
	end

	// count down while the line is held; done pulses on release
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= '0;
			ifc_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			if (start && !ifc_q) begin
				cnt_q <= CW'(CYCLES - 1);
				ifc_q <= 1'b1;
			end else if (ifc_q) begin
				if (cnt_q == '0) begin
					ifc_q <= 1'b0;
					done_q <= 1'b1;
				end else begin
					cnt_q <= cnt_q - 1'b1;
				end
			end
		end
	end
endmodule : isd_ifc_timer

// [tb/isd_cmd_decoder_chk.sv]
`timescale 1ns/10ps
// port-level watch on handshakes, phase order and the clear pulse
module isd_chk (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// selection and streams
	input wire logic sel_req,
	input wire logic sel_atn,
	input wire logic ini_valid,
	input wire logic ini_ready_q,
	input wire logic [7:0] tgt_data_q,
	input wire logic tgt_valid_q,
	input wire logic tgt_ready,
	input wire logic [7:0] bus_tx_data_q,
	input wire logic bus_tx_valid_q,
	input wire logic bus_tx_ready,
	// status
	input wire isd_pkg::isd_phase_t phase_q,
	input wire logic exec_start_q,
	input wire logic ifc_active_q
);
	localparam int IFC_N = isd_pkg::IFC_CYCLES;
	logic [13:0] ifc_cnt_q;
	// width of the clear pulse; an assertion is too slow to unroll 12500 cycles
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			ifc_cnt_q <= 14'h0000;
		else if (ifc_active_q)
			ifc_cnt_q <= ifc_cnt_q + 14'h0001;
		else
			ifc_cnt_q <= 14'h0000;
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	chk_ifc_width: assert property ($fell(ifc_active_q) |-> ifc_cnt_q == IFC_N)
		else $error("clear pulse width wrong");
	chk_start_pulse: assert property (exec_start_q |=> !exec_start_q)
		else $error("start pulse longer than one cycle");
	chk_tgt_hold: assert property (tgt_valid_q && !tgt_ready |=> tgt_valid_q && $stable(tgt_data_q))
		else $error("target byte dropped before take");
	chk_ini_gap: assert property (ini_valid && ini_ready_q |=> !ini_ready_q)
		else $error("ready did not drop after take");
	chk_status_msg: assert property (phase_q == isd_pkg::PH_STATUS ##1
		phase_q != isd_pkg::PH_STATUS |-> phase_q == isd_pkg::PH_MSG_IN)
		else $error("status not followed by message in");
	chk_tx_hold: assert property (bus_tx_valid_q && !bus_tx_ready |=> bus_tx_valid_q && $stable(bus_tx_data_q))
		else $error("bus byte dropped before take");
	chk_atn_msgout: assert property (sel_req && sel_atn && phase_q == isd_pkg::PH_FREE
		|-> ##[1:3] phase_q == isd_pkg::PH_MSG_OUT)
		else $error("attention selection missed message out");
	chk_sel_command: assert property (sel_req && !sel_atn && phase_q == isd_pkg::PH_FREE
		|-> ##[1:3] phase_q == isd_pkg::PH_COMMAND)
		else $error("plain selection missed command phase");
endmodule : isd_chk

bind isd_cmd_decoder isd_chk u_chk (.sys_clk, .rst_n, .sel_req, .sel_atn, .ini_valid,
	.ini_ready_q, .tgt_data_q, .tgt_valid_q, .tgt_ready, .bus_tx_data_q, .bus_tx_valid_q,
	.bus_tx_ready, .phase_q, .exec_start_q, .ifc_active_q);

// [tb/isd_ini_model.sv]
`timescale 1ns/10ps
// initiator: sends bytes on request, takes target bytes and logs them with their phase
module isd_ini_model (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// initiator stream
	output logic [7:0] ini_data,
	output logic ini_valid,
	input wire logic ini_ready_q,
	// target stream
	input wire logic [7:0] tgt_data_q,
	input wire logic tgt_valid_q,
	output logic tgt_ready,
	input wire isd_pkg::isd_phase_t phase_q,
	// pacing
	input wire logic slow
);
	logic [10:0] rx_q[$];
	logic [7:0] last_d;
	logic took;
	initial begin
		ini_data = 8'h00;
		ini_valid = 1'b0;
		tgt_ready = 1'b0;
	end
	// held until the edge that sees ready, then the line shows the inverse, not stale data
	task automatic put(input logic [7:0] b);
		@(posedge sys_clk);
		ini_data <= b;
		ini_valid <= 1'b1;
		do @(negedge sys_clk); while (ini_ready_q !== 1'b1);
		@(posedge sys_clk);
		ini_valid <= 1'b0;
		ini_data <= ~b;
	endtask : put
	// slow mode stalls every other cycle so the target must hold its byte
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			tgt_ready <= 1'b0;
			took <= 1'b0;
		end else begin
			tgt_ready <= slow ? ~tgt_ready : 1'b1;
			took <= tgt_valid_q && tgt_ready;
			last_d <= tgt_data_q;
			// phase lags the byte by a cycle, so it is logged on the edge after the take
			if (took)
				rx_q.push_back({phase_q, last_d});
		end
	end
endmodule : isd_ini_model

// [tb/isd_cmd_decoder_tb.sv]
`timescale 1ns/10ps
`define CHK_EQ(g, e) begin cmp_count++; if ((g) !== (e)) begin n_errors++; $display("[ERR] t=%0t got %h exp %h", $time, (g), (e)); end end
module isd_cmd_decoder_tb;
	logic sys_clk, rst_n, sel_req, sel_atn, cont_status_en, slow;
	logic [7:0] ini_data, tgt_data_q, bus_rx_data, bus_tx_data_q;
	logic ini_valid, ini_ready_q, tgt_valid_q, tgt_ready, disc_allowed_q;
	logic bus_rx_valid, bus_rx_end, bus_rx_ready_q, bus_tx_valid_q, bus_tx_ready;
	logic exec_start_q, exec_done, exec_error, ifc_active_q, done_en, err_en;
	logic [39:0] exec_args_q, args_seen;
	logic [3:0] sense_key_q;
	logic [1:0] pend;
	isd_pkg::isd_phase_t phase_q;
	isd_pkg::isd_fn_t exec_fn_q, fn_seen;
	int n_errors, cmp_count, n_start;
	logic [7:0] tx_q[$];

	isd_cmd_decoder DUT (.sys_clk, .rst_n, .sel_req, .sel_atn, .cont_status_en, .ini_data,
		.ini_valid, .ini_ready_q, .tgt_data_q, .tgt_valid_q, .tgt_ready, .phase_q,
		.disc_allowed_q, .bus_rx_data, .bus_rx_valid, .bus_rx_end, .bus_rx_ready_q,
		.bus_tx_data_q, .bus_tx_valid_q, .bus_tx_ready, .exec_fn_q, .exec_args_q,
		.exec_start_q, .exec_done, .exec_error, .ifc_active_q, .sense_key_q);
	isd_ini_model INI (.sys_clk, .rst_n, .ini_data, .ini_valid, .ini_ready_q, .tgt_data_q,
		.tgt_valid_q, .tgt_ready, .phase_q, .slow);

	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	// executor answers two cycles after start; bus source counts up, sink stalls
	always @(posedge sys_clk) begin
		exec_done <= 1'b0;
		if (exec_start_q) begin
			pend <= 2'h1;
			n_start++;
			fn_seen <= exec_fn_q;
			args_seen <= exec_args_q;
		end else if (pend == 2'h1)
			pend <= 2'h2;
		else if (pend == 2'h2 && done_en) begin
			exec_done <= 1'b1;
			exec_error <= err_en;
			pend <= 2'h0;
		end
		if (bus_rx_valid && bus_rx_ready_q)
			bus_rx_data <= bus_rx_data + 8'h01;
		bus_tx_ready <= ~bus_tx_ready;
		if (bus_tx_valid_q && bus_tx_ready)
			tx_q.push_back(bus_tx_data_q);
	end
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : print_verdict
	// selection only from bus free, identify when asked, six cdb bytes, then data out
	task automatic run(input logic atn, input logic [7:0] op, input logic [39:0] a, input int nout);
		INI.rx_q.delete();
		tx_q.delete();
		n_start = 0;
		@(posedge sys_clk);
		sel_req <= 1'b1;
		sel_atn <= atn;
		@(posedge sys_clk);
		sel_req <= 1'b0;
		sel_atn <= 1'b0;
		if (atn)
			INI.put(8'hc0);
		INI.put(op);
		for (int k = 4; k >= 0; k--)
			INI.put(a[k*8 +: 8]);
		for (int k = 0; k < nout; k++)
			INI.put(8'h60 + 8'(k));
	endtask : run
	task automatic wait_rx(input int n, input logic chk);
		for (int i = 0; i < 20000 && INI.rx_q.size() < n; i++)
			@(negedge sys_clk);
		repeat (3) @(negedge sys_clk);
		if (chk)
			`CHK_EQ(INI.rx_q.size(), n)
	endtask : wait_rx
	// status byte then exactly one completion message
	task automatic tail(input int i, input logic [7:0] st);
		`CHK_EQ(INI.rx_q[i], {isd_pkg::PH_STATUS, st})
		`CHK_EQ(INI.rx_q[i+1], {isd_pkg::PH_MSG_IN, isd_pkg::MSG_COMPLETE})
		`CHK_EQ(phase_q, isd_pkg::PH_FREE)
	endtask : tail
	// opcodes in class order; non-data ones other than the clear pulse reach the executor with their class
	task automatic t_decode();
		logic [7:0] ops[32] = '{8'hdd, 8'hdc, 8'hcf, 8'hdb, 8'hc0, 8'hc7, 8'hcc, 8'hd5,
			8'hc2, 8'hc3, 8'hca, 8'hd9, 8'hd6, 8'hd2, 8'hc1, 8'hc5, 8'hc6, 8'hcb, 8'hd1,
			8'hd8, 8'hd3, 8'hd4, 8'hd0, 8'hc9, 8'hcd, 8'hce, 8'h12, 8'h03, 8'hc8, 8'hde, 8'hd7,
			8'hda};
		for (int i = 4; i < 32; i++) begin
			// the clear pulse never reaches the executor; it has its own scenario
			if (i == 7)
				continue;
			slow = i[0];
			run(1'b0, ops[i], 40'h0102030400, 0);
			wait_rx(2, 1'b1);
			`CHK_EQ(n_start, 1)
			`CHK_EQ(fn_seen, isd_pkg::isd_fn_t'(i + 1))
			`CHK_EQ(args_seen, 40'h0102030400)
			tail(0, isd_pkg::ST_GOOD);
		end
	endtask : t_decode
	task automatic t_ifc();
		int n;
		run(1'b0, 8'hd5, 40'h0, 0);
		for (n = 0; n < 20 && ifc_active_q !== 1'b1; n++)
			@(negedge sys_clk);
		for (n = 0; ifc_active_q === 1'b1 && n < 20000; n++)
			@(negedge sys_clk);
		`CHK_EQ(n, isd_pkg::IFC_CYCLES)
		wait_rx(2, 1'b1);
		tail(0, isd_pkg::ST_GOOD);
	endtask : t_ifc
	// nonzero reserved byte, then an unknown opcode; neither may run
	task automatic t_reject();
		for (int i = 0; i < 2; i++) begin
			run(1'b0, i ? 8'h55 : 8'hc0, i ? 40'h0 : 40'h01, 0);
			wait_rx(2, 1'b1);
			`CHK_EQ(n_start, 0)
			`CHK_EQ(sense_key_q, isd_pkg::SENSE_ILLEGAL)
			tail(0, isd_pkg::ST_CHECK);
		end
		err_en = 1'b1;
		run(1'b0, 8'hc2, 40'h0, 0);
		wait_rx(2, 1'b1);
		tail(0, isd_pkg::ST_CHECK);
		err_en = 1'b0;
	endtask : t_reject
	// raw receive with attention: bus bytes reach the initiator in order
	task automatic t_data_in();
		logic [7:0] b;
		b = bus_rx_data;
		done_en = 1'b0;
		slow = 1'b1;
		run(1'b1, 8'hdd, 40'h0000000300, 0);
		wait_rx(3, 1'b0);
		`CHK_EQ(disc_allowed_q, 1'b1)
		done_en = 1'b1;
		wait_rx(5, 1'b1);
		for (int k = 0; k < 3; k++)
			`CHK_EQ(INI.rx_q[k], {isd_pkg::PH_DATA_IN, b + 8'(k)})
		tail(3, isd_pkg::ST_GOOD);
		run(1'b1, 8'hc2, 40'h0, 0);
		repeat (4) @(negedge sys_clk);
		`CHK_EQ(disc_allowed_q, 1'b0)
		wait_rx(2, 1'b1);
	endtask : t_data_in
	// raw send, addressed write, command send: initiator bytes go out on the bus unchanged
	task automatic t_data_out();
		logic [7:0] ops[3] = '{8'hdc, 8'hdb, 8'hc4};
		for (int j = 0; j < 3; j++) begin
			run(1'b0, ops[j], 40'h0000000200, 2);
			wait_rx(2, 1'b1);
			`CHK_EQ({tx_q[0], tx_q[1]}, 16'h6061)
			tail(0, isd_pkg::ST_GOOD);
		end
	endtask : t_data_out
	task automatic t_cont();
		cont_status_en = 1'b1;
		run(1'b0, 8'hc0, 40'h0, 0);
		wait_rx(3, 1'b1);
		`CHK_EQ(INI.rx_q[0], {isd_pkg::PH_MSG_IN, isd_pkg::MSG_STATUS_REPORT})
		tail(1, isd_pkg::ST_GOOD);
		cont_status_en = 1'b0;
	endtask : t_cont
	initial begin
		repeat (40000) @(posedge sys_clk);
		n_errors++;
		print_verdict();
	end
	initial begin
		rst_n = 1'b0;
		{sel_req, sel_atn, cont_status_en, slow, bus_rx_end, bus_tx_ready} = 6'h00;
		{exec_done, exec_error, err_en, pend} = 5'h00;
		bus_rx_data = 8'ha0;
		bus_rx_valid = 1'b1;
		done_en = 1'b1;
		n_errors = 0;
		cmp_count = 0;
		n_start = 0;
		repeat (3) @(posedge sys_clk);
		rst_n <= 1'b1;
		t_decode();
		t_ifc();
		t_reject();
		t_data_in();
		t_data_out();
		t_cont();
		print_verdict();
	end
endmodule : isd_cmd_decoder_tb
